/* File: hw/uefc_pkg.sv */
/*
 * Package for the enhanced-feature and flow-control logic of one UART channel:
 * register addresses, field positions, reset values, interrupt codes, trigger tables
 * and the packed host bus request.
 * Assumes a synchronous 8-bit host bus sampled on mclk_i.
 */
package uefc_pkg;

    // register addresses on the 3-bit host bus
    localparam logic [2:0] ADDR_HOLD   = 3'h0;  // receive/transmit holding, divisor low
    localparam logic [2:0] ADDR_IER    = 3'h1;  // interrupt enable, divisor high
    localparam logic [2:0] ADDR_IIR    = 3'h2;  // id (read), fifo control (write), feature
    localparam logic [2:0] ADDR_LCR    = 3'h3;
    localparam logic [2:0] ADDR_MCR    = 3'h4;
    localparam logic [2:0] ADDR_LSR    = 3'h5;
    localparam logic [2:0] ADDR_TCR    = 3'h6;  // flow thresholds or modem status
    localparam logic [2:0] ADDR_TLR    = 3'h7;  // trigger levels, ready status, xoff2

    // line control keys
    localparam logic [7:0] LCR_EXT_KEY = 8'hbf;
    localparam int         LCR_DLAB    = 7;

    // interrupt enable fields
    localparam int IER_RX    = 0;
    localparam int IER_TX    = 1;
    localparam int IER_LS    = 2;
    localparam int IER_MS    = 3;
    localparam int IER_SLEEP = 4;
    localparam int IER_XOFF  = 5;
    localparam int IER_RTS   = 6;
    localparam int IER_CTS   = 7;

    // feature enable fields
    localparam int EFR_WE      = 4;
    localparam int EFR_SPECIAL = 5;
    localparam int EFR_ARTS    = 6;
    localparam int EFR_ACTS    = 7;

    // modem control fields
    localparam int MCR_RTS     = 1;
    localparam int MCR_FRDY    = 2;
    localparam int MCR_LOOP    = 4;
    localparam int MCR_TLR_ACC = 6;

    localparam int FCR_EN      = 0;

    // bits guarded by the feature write enable
    localparam logic [7:0] IER_PROT_MASK = 8'hf0;
    localparam logic [7:0] FCR_PROT_MASK = 8'h30;
    localparam logic [7:0] MCR_PROT_MASK = 8'he0;

    localparam logic [7:0] REG_RESET = 8'h00;

    // interrupt source codes, bits 5:0
    localparam logic [5:0] IIR_NONE    = 6'h01;
    localparam logic [5:0] IIR_LINE    = 6'h06;
    localparam logic [5:0] IIR_TIMEOUT = 6'h0c;
    localparam logic [5:0] IIR_RXDATA  = 6'h04;
    localparam logic [5:0] IIR_TXHOLD  = 6'h02;
    localparam logic [5:0] IIR_MODEM   = 6'h00;
    localparam logic [5:0] IIR_XOFF    = 6'h10;
    localparam logic [5:0] IIR_CTSRTS  = 6'h20;

    // fifo-control trigger levels, selected by fcr[7:6] (rx) and fcr[5:4] (tx)
    localparam logic [5:0] RX_FCR_TRIG0 = 6'h08;
    localparam logic [5:0] RX_FCR_TRIG1 = 6'h10;
    localparam logic [5:0] RX_FCR_TRIG2 = 6'h38;
    localparam logic [5:0] RX_FCR_TRIG3 = 6'h3c;
    localparam logic [5:0] TX_FCR_TRIG0 = 6'h08;
    localparam logic [5:0] TX_FCR_TRIG1 = 6'h10;
    localparam logic [5:0] TX_FCR_TRIG2 = 6'h20;
    localparam logic [5:0] TX_FCR_TRIG3 = 6'h38;

    // fifo ready status bit positions
    localparam int FRR_TX_A = 0;
    localparam int FRR_TX_B = 1;
    localparam int FRR_RX_A = 4;
    localparam int FRR_RX_B = 5;

    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 8;

    typedef struct packed {
        logic       sel_n;  // chip select, active low
        logic       rd;     // one-cycle read strobe
        logic       wr;     // one-cycle write strobe
        logic [2:0] addr;
        logic [7:0] wdata;
    } uefc_bus_s;

endpackage

/* File: hw/uefc_channel.sv */
/*
 * Enhanced-feature and flow-control logic of one UART channel, with a
 * parameterised FIFO module used for the receive and transmit character paths.
 * Assumes a character deserialiser feeding rx_* and a shifter draining tx_*,
 * all on mclk_i; the partner channel supplies its own ready bits.
 */
`timescale 1ns/10ps

module uefc_fifo #(
    parameter int WIDTH = uefc_pkg::FIFO_WIDTH,
    parameter int DEPTH = uefc_pkg::FIFO_DEPTH,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic             mclk_i,
    input  wire logic             reset_i,
    input  wire logic             ce_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o,
    output logic      [CW-1:0]    count_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    rptr_q;
    logic [CW-1:0]    count_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_q != CW'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = mem_q[rptr_q];
    assign count_o     = count_q;
    assign push        = ce_i && in_valid_i && in_ready_o;
    assign pop         = ce_i && out_valid_o && out_ready_i;

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_q[wptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
            end
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end
endmodule

module uefc_channel #(
    parameter int DEPTH = uefc_pkg::FIFO_DEPTH,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic                mclk_i,
    input  wire logic                reset_i,
    input  wire logic                ce_i,
    input  wire uefc_pkg::uefc_bus_s bus_i,
    output logic [7:0]               rdata_o,
    input  wire logic                rx_valid_i,
    input  wire logic [7:0]          rx_data_i,
    output logic                     rx_ready_o,
    input  wire logic                rx_error_i,
    input  wire logic                rx_timeout_i,
    input  wire logic                modem_change_i,
    output logic                     tx_valid_o,
    output logic [7:0]               tx_data_o,
    input  wire logic                tx_ready_i,
    input  wire logic                cts_n_i,
    output logic                     rts_n_o,
    output logic [15:0]              divisor_o,
    output logic [3:0]               sw_flow_mode_o,
    output logic                     sleep_o,
    input  wire logic                peer_tx_rdy_i,
    input  wire logic                peer_rx_rdy_i,
    output logic                     tx_rdy_o,
    output logic                     rx_rdy_o
);
    logic [7:0] ier_q, fcr_q, lcr_q, mcr_q, efr_q, dll_q, dlh_q, tcr_q, tlr_q, xoff2_q;
    logic [7:0] rdata_q;
    logic       xoff_flag_q, flow_flag_q, rts_auto_n_q, cts_n_q, rts_n_q;
    logic       wr_en, rd_en, ext_mode, dlab, tl_access, frr_access;
    logic [CW-1:0] rx_count, tx_count;
    logic [6:0] rx_level, tx_space, halt_lvl, resume_lvl;
    logic [5:0] rx_trig, tx_trig, iir_code;
    logic [7:0] rx_head, frr_val, iir_val, lsr_val, msr_val;
    logic       rx_head_valid, rx_pop, tx_push, tx_fifo_valid, tx_fifo_ready;
    logic       rx_at_trig, tx_at_trig, special_hit, tx_gate;

    assign wr_en      = ce_i && !bus_i.sel_n && bus_i.wr;
    assign rd_en      = ce_i && !bus_i.sel_n && bus_i.rd;
    assign ext_mode   = (lcr_q == uefc_pkg::LCR_EXT_KEY);
    assign dlab       = lcr_q[uefc_pkg::LCR_DLAB];
    assign tl_access  = efr_q[uefc_pkg::EFR_WE] && mcr_q[uefc_pkg::MCR_TLR_ACC];
    assign frr_access = mcr_q[uefc_pkg::MCR_FRDY] && !mcr_q[uefc_pkg::MCR_LOOP];

    // receive path: back-pressure reaches the deserialiser through rx_ready_o
    assign rx_pop = rd_en && (bus_i.addr == uefc_pkg::ADDR_HOLD) && !dlab;

    uefc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .ce_i        (ce_i),
        .in_valid_i  (rx_valid_i),
        .in_ready_o  (rx_ready_o),
        .in_data_i   (rx_data_i),
        .out_valid_o (rx_head_valid),
        .out_ready_i (rx_pop),
        .out_data_o  (rx_head),
        .count_o     (rx_count)
    );

    // transmit path: a write to a full fifo is dropped
    assign tx_push = wr_en && (bus_i.addr == uefc_pkg::ADDR_HOLD) && !dlab;
    // gating only the handshake lets a character already taken by the shifter finish
    assign tx_gate    = efr_q[uefc_pkg::EFR_ACTS] && cts_n_i;
    assign tx_valid_o = tx_fifo_valid && !tx_gate;
    assign tx_fifo_ready = tx_ready_i && !tx_gate;

    uefc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .ce_i        (ce_i),
        .in_valid_i  (tx_push),
        .in_ready_o  (),
        .in_data_i   (bus_i.wdata),
        .out_valid_o (tx_fifo_valid),
        .out_ready_i (tx_fifo_ready),
        .out_data_o  (tx_data_o),
        .count_o     (tx_count)
    );

    // plain register writes
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            lcr_q   <= uefc_pkg::REG_RESET;
            efr_q   <= uefc_pkg::REG_RESET;
            xoff2_q <= uefc_pkg::REG_RESET;
        end else if (wr_en) begin
            if (bus_i.addr == uefc_pkg::ADDR_LCR) begin
                lcr_q <= bus_i.wdata;
            end
            if (ext_mode && bus_i.addr == uefc_pkg::ADDR_IIR) begin
                efr_q <= bus_i.wdata;
            end
            if (ext_mode && bus_i.addr == uefc_pkg::ADDR_TLR) begin
                xoff2_q <= bus_i.wdata;
            end
        end
    end

    // registers with guarded fields
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ier_q <= uefc_pkg::REG_RESET;
            fcr_q <= uefc_pkg::REG_RESET;
            mcr_q <= uefc_pkg::REG_RESET;
        end else if (wr_en && !ext_mode) begin
            if (bus_i.addr == uefc_pkg::ADDR_IER && !dlab) begin
                ier_q <= efr_q[uefc_pkg::EFR_WE] ? bus_i.wdata :
                    ((ier_q & uefc_pkg::IER_PROT_MASK) | (bus_i.wdata & ~uefc_pkg::IER_PROT_MASK));
            end
            if (bus_i.addr == uefc_pkg::ADDR_IIR) begin
                fcr_q <= efr_q[uefc_pkg::EFR_WE] ? bus_i.wdata :
                    ((fcr_q & uefc_pkg::FCR_PROT_MASK) | (bus_i.wdata & ~uefc_pkg::FCR_PROT_MASK));
            end
            if (bus_i.addr == uefc_pkg::ADDR_MCR) begin
                mcr_q <= efr_q[uefc_pkg::EFR_WE] ? bus_i.wdata :
                    ((mcr_q & uefc_pkg::MCR_PROT_MASK) | (bus_i.wdata & ~uefc_pkg::MCR_PROT_MASK));
            end
        end
    end

    // divisor latches freeze once sleep is enabled
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            dll_q <= uefc_pkg::REG_RESET;
            dlh_q <= uefc_pkg::REG_RESET;
        end else if (wr_en && dlab && !ext_mode && !ier_q[uefc_pkg::IER_SLEEP]) begin
            if (bus_i.addr == uefc_pkg::ADDR_HOLD) begin
                dll_q <= bus_i.wdata;
            end
            if (bus_i.addr == uefc_pkg::ADDR_IER) begin
                dlh_q <= bus_i.wdata;
            end
        end
    end

    assign divisor_o      = {dlh_q, dll_q};
    assign sw_flow_mode_o = efr_q[3:0];
    assign sleep_o        = ier_q[uefc_pkg::IER_SLEEP];

    // thresholds and trigger levels
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            tcr_q <= uefc_pkg::REG_RESET;
            tlr_q <= uefc_pkg::REG_RESET;
        end else if (wr_en && tl_access && !ext_mode) begin
            if (bus_i.addr == uefc_pkg::ADDR_TCR) begin
                tcr_q <= bus_i.wdata;
            end
            if (bus_i.addr == uefc_pkg::ADDR_TLR) begin
                tlr_q <= bus_i.wdata;
            end
        end
    end

    // no ordering check on halt against resume: software's duty
    assign halt_lvl   = {1'b0, tcr_q[3:0], 2'b00};
    assign resume_lvl = {1'b0, tcr_q[7:4], 2'b00};
    assign rx_level   = 7'(rx_count);
    assign tx_space   = 7'(DEPTH) - 7'(tx_count);

    always_comb begin
        case (fcr_q[7:6])
            2'b00:   rx_trig = uefc_pkg::RX_FCR_TRIG0;
            2'b01:   rx_trig = uefc_pkg::RX_FCR_TRIG1;
            2'b10:   rx_trig = uefc_pkg::RX_FCR_TRIG2;
            default: rx_trig = uefc_pkg::RX_FCR_TRIG3;
        endcase
        if (tlr_q[7:4] != 4'h0) begin
            rx_trig = {tlr_q[7:4], 2'b00};
        end
        case (fcr_q[5:4])
            2'b00:   tx_trig = uefc_pkg::TX_FCR_TRIG0;
            2'b01:   tx_trig = uefc_pkg::TX_FCR_TRIG1;
            2'b10:   tx_trig = uefc_pkg::TX_FCR_TRIG2;
            default: tx_trig = uefc_pkg::TX_FCR_TRIG3;
        endcase
        if (tlr_q[3:0] != 4'h0) begin
            tx_trig = {tlr_q[3:0], 2'b00};
        end
    end

    assign rx_at_trig = (rx_level >= {1'b0, rx_trig});
    assign tx_at_trig = (tx_space >= {1'b0, tx_trig});
    assign tx_rdy_o   = tx_at_trig;
    assign rx_rdy_o   = rx_at_trig || rx_timeout_i;

    // auto-rts with hysteresis between halt and resume levels
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            rts_auto_n_q <= 1'b0;
        end else if (ce_i) begin
            if (rx_level >= halt_lvl) begin
                rts_auto_n_q <= 1'b1;
            end else if (rx_level <= resume_lvl) begin
                rts_auto_n_q <= 1'b0;
            end
        end
    end

    assign rts_n_o = efr_q[uefc_pkg::EFR_ARTS] ? rts_auto_n_q : !mcr_q[uefc_pkg::MCR_RTS];

    // sticky events, cleared by reading the id register; a new event wins
    assign special_hit = ce_i && efr_q[uefc_pkg::EFR_SPECIAL] && rx_valid_i && rx_ready_o
                      && (rx_data_i == xoff2_q);

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            // idle level is inactive high, so no false rising edge after reset
            cts_n_q     <= 1'b1;
            rts_n_q     <= 1'b1;
            xoff_flag_q <= 1'b0;
            flow_flag_q <= 1'b0;
        end else if (ce_i) begin
            cts_n_q <= cts_n_i;
            rts_n_q <= rts_n_o;
            if (rd_en && bus_i.addr == uefc_pkg::ADDR_IIR && !ext_mode) begin
                xoff_flag_q <= 1'b0;
                flow_flag_q <= 1'b0;
            end
            if (special_hit) begin
                xoff_flag_q <= 1'b1;
            end
            if ((cts_n_i && !cts_n_q) || (rts_n_o && !rts_n_q)) begin
                flow_flag_q <= 1'b1;
            end
        end
    end

    // fixed priority, only the winner shows
    always_comb begin
        if (ier_q[uefc_pkg::IER_LS] && rx_error_i) begin
            iir_code = uefc_pkg::IIR_LINE;
        end else if (ier_q[uefc_pkg::IER_RX] && rx_timeout_i) begin
            iir_code = uefc_pkg::IIR_TIMEOUT;
        end else if (ier_q[uefc_pkg::IER_RX] && rx_at_trig && rx_head_valid) begin
            iir_code = uefc_pkg::IIR_RXDATA;
        end else if (ier_q[uefc_pkg::IER_TX] && tx_at_trig) begin
            iir_code = uefc_pkg::IIR_TXHOLD;
        end else if (ier_q[uefc_pkg::IER_MS] && modem_change_i) begin
            iir_code = uefc_pkg::IIR_MODEM;
        end else if (ier_q[uefc_pkg::IER_XOFF] && xoff_flag_q) begin
            iir_code = uefc_pkg::IIR_XOFF;
        end else if ((ier_q[uefc_pkg::IER_RTS] || ier_q[uefc_pkg::IER_CTS]) && flow_flag_q) begin
            iir_code = uefc_pkg::IIR_CTSRTS;
        end else begin
            iir_code = uefc_pkg::IIR_NONE;
        end
    end

    assign iir_val = {{2{fcr_q[uefc_pkg::FCR_EN]}}, iir_code};

    // this instance is channel a; the peer channel supplies the b bits
    always_comb begin
        frr_val = 8'h00;
        frr_val[uefc_pkg::FRR_TX_A] = tx_rdy_o;
        frr_val[uefc_pkg::FRR_TX_B] = peer_tx_rdy_i;
        frr_val[uefc_pkg::FRR_RX_A] = rx_rdy_o;
        frr_val[uefc_pkg::FRR_RX_B] = peer_rx_rdy_i;
    end

    assign lsr_val = {1'b0, !tx_fifo_valid, !tx_fifo_valid, 4'h0, rx_head_valid};
    assign msr_val = {3'h0, !cts_n_i, 4'h0};

    // read answer registered, one cycle after the strobe
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q <= 8'h00;
        end else if (rd_en) begin
            case (bus_i.addr)
                uefc_pkg::ADDR_HOLD: rdata_q <= dlab ? dll_q : rx_head;
                uefc_pkg::ADDR_IER:  rdata_q <= dlab ? dlh_q : ier_q;
                uefc_pkg::ADDR_IIR:  rdata_q <= ext_mode ? efr_q : iir_val;
                uefc_pkg::ADDR_LCR:  rdata_q <= lcr_q;
                uefc_pkg::ADDR_MCR:  rdata_q <= mcr_q;
                uefc_pkg::ADDR_LSR:  rdata_q <= lsr_val;
                uefc_pkg::ADDR_TCR:  rdata_q <= tl_access ? tcr_q : msr_val;
                uefc_pkg::ADDR_TLR: begin
                    if (ext_mode) begin
                        rdata_q <= xoff2_q;
                    end else if (tl_access) begin
                        rdata_q <= tlr_q;
                    end else if (frr_access) begin
                        rdata_q <= frr_val;
                    end else begin
                        rdata_q <= 8'h00;
                    end
                end
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign rdata_o = rdata_q;
endmodule

/* File: bench/uefc_asserts.sv */
/* port-level checker for uefc_channel.
   assumes ce_i mostly high and one bus request per strobe. */
`timescale 1ns/10ps
module uefc_asserts (
    input wire logic                mclk_i,
    input wire logic                reset_i,
    input wire logic                ce_i,
    input wire uefc_pkg::uefc_bus_s bus_i,
    input wire logic [7:0]          rdata_o,
    input wire logic                rx_timeout_i,
    input wire logic                rx_rdy_o,
    input wire logic                tx_valid_o,
    input wire logic [7:0]          tx_data_o,
    input wire logic                tx_ready_i,
    input wire logic                cts_n_i,
    input wire logic                rts_n_o,
    input wire logic [15:0]         divisor_o,
    input wire logic [3:0]          sw_flow_mode_o,
    input wire logic                sleep_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    wire logic wr_s = !bus_i.sel_n && bus_i.wr && ce_i;
    wire logic rd_s = !bus_i.sel_n && bus_i.rd && ce_i;
    divisor_lock_a: assert property (sleep_o |=> $stable(divisor_o))
        else $error("divisor changed in sleep");
    divisor_hold_a: assert property (!wr_s |=> $stable(divisor_o))
        else $error("divisor changed without write");
    mode_hold_a: assert property (!wr_s |=> $stable(sw_flow_mode_o))
        else $error("flow mode changed without write");
    sleep_hold_a: assert property (!wr_s |=> $stable(sleep_o))
        else $error("sleep changed without write");
    timeout_rdy_a: assert property (rx_timeout_i |-> rx_rdy_o)
        else $error("timeout not on rx ready");
    tx_head_a: assert property (tx_valid_o && !tx_ready_i |=> $stable(tx_data_o))
        else $error("tx head changed while stalled");
    tx_keep_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o || cts_n_i)
        else $error("tx valid dropped with cts low");
    rdata_hold_a: assert property (!rd_s |=> $stable(rdata_o))
        else $error("read data changed without read");
    cover property (tx_valid_o && tx_ready_i);
    cover property ($rose(rts_n_o));
    cover property (rx_timeout_i && rd_s);
endmodule
bind uefc_channel uefc_asserts u_chk (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .rx_timeout_i(rx_timeout_i), .rx_rdy_o(rx_rdy_o),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
    .cts_n_i(cts_n_i), .rts_n_o(rts_n_o), .divisor_o(divisor_o),
    .sw_flow_mode_o(sw_flow_mode_o), .sleep_o(sleep_o));

/* File: bench/uefc_shifter.sv */
/* transmit shifter model: takes characters with random stalls.
   assumes the bench seeds the random source. */
`timescale 1ns/10ps
module uefc_shifter (
    input  wire logic       mclk_i,
    input  wire logic       run_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_ready_o
);
    logic [7:0] got_q[$];
    initial tx_ready_o = 1'b0;
    always @(posedge mclk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            got_q.push_back(tx_data_i);
        end
        // one stall in three keeps the head waiting
        tx_ready_o <= run_i && ($urandom_range(0, 2) != 0);
    end
endmodule

/* File: bench/tb_top.sv */
/* self-checking bench for uefc_channel.
   assumes the shifter model drains the transmit side. */
`timescale 1ns/10ps
module tb_top;
    logic                mclk_i = 1'b0;
    logic                reset_i = 1'b1;
    uefc_pkg::uefc_bus_s bus = 14'h2000;
    logic rxv = 0, rxe = 0, rxt = 0, mdm = 0, cts_n = 0, prx = 0, ptx = 0, run = 0;
    logic [7:0]          rxd = 8'h00, rdata, txd, x, dh, dl;
    logic                rxr, txv, txr, rts_n, rrdy, trdy, slp;
    logic [15:0]         div;
    logic [3:0]          mode;
    logic [7:0]          q[$];
    logic [2:0]          src [5] = '{3'h7, 3'h3, 3'h1, 3'h1, 3'h0};
    logic [5:0]          cd [5] = '{uefc_pkg::IIR_LINE, uefc_pkg::IIR_TIMEOUT,
        uefc_pkg::IIR_TXHOLD, uefc_pkg::IIR_MODEM, uefc_pkg::IIR_NONE};
    int                  n_mismatch = 0, samples_checked = 0, k;
    always #5 mclk_i = ~mclk_i;
    uefc_channel u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(1'b1), .bus_i(bus),
        .rdata_o(rdata), .rx_valid_i(rxv), .rx_data_i(rxd), .rx_ready_o(rxr),
        .rx_error_i(rxe), .rx_timeout_i(rxt), .modem_change_i(mdm), .tx_valid_o(txv),
        .tx_data_o(txd), .tx_ready_i(txr), .cts_n_i(cts_n), .rts_n_o(rts_n),
        .divisor_o(div), .sw_flow_mode_o(mode), .sleep_o(slp), .peer_tx_rdy_i(ptx),
        .peer_rx_rdy_i(prx), .tx_rdy_o(trdy), .rx_rdy_o(rrdy));
    uefc_shifter u_sh (.mclk_i(mclk_i), .run_i(run), .tx_valid_i(txv), .tx_data_i(txd),
        .tx_ready_o(txr));
    function automatic logic [7:0] iir_f(logic f, logic [5:0] c);
        return {f, f, c};
    endfunction
    function automatic int lvl(logic [3:0] f);
        return 4 * f;
    endfunction
    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic w(logic [2:0] a, logic [7:0] d);
        @(posedge mclk_i) bus <= {3'b001, a, d};
        @(posedge mclk_i) bus <= 14'h2000;
        // let the write edge settle before anyone looks at outputs
        #1;
    endtask
    task automatic r(logic [2:0] a, logic [7:0] e);
        @(posedge mclk_i) bus <= {3'b010, a, 8'h00};
        @(posedge mclk_i) bus <= 14'h2000;
        #1 chk("rdata", {8'h00, rdata}, {8'h00, e});
    endtask
    task automatic push(logic [7:0] d);
        @(posedge mclk_i) begin
            rxv <= 1'b1;
            rxd <= d;
        end
        @(posedge mclk_i) rxv <= 1'b0;
        q.push_back(d);
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'hc36d));
        repeat (16) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1 chk("reset", {rts_n, txv, rxr, slp, div[11:0]}, 16'ha000);
        w(3'h1, 8'h10);
        chk("sleep", 16'(slp), 16'h0000);
        x = 8'($urandom());
        w(3'h3, 8'hbf);
        w(3'h2, {4'h1, x[3:0]});
        chk("mode", 16'(mode), 16'(x[3:0]));
        w(3'h7, x);
        w(3'h3, 8'h80);
        dl = 8'($urandom());
        dh = 8'($urandom());
        w(3'h0, dl);
        w(3'h1, dh);
        chk("divisor", div, {dh, dl});
        w(3'h3, 8'h00);
        w(3'h1, 8'h30);
        chk("sleep", 16'(slp), 16'h0001);
        w(3'h3, 8'h80);
        w(3'h0, ~dl);
        chk("divisor", div, {dh, dl});
        w(3'h3, 8'h00);
        w(3'h1, 8'h20);
        w(3'h6, 8'h55);
        w(3'h4, 8'h40);
        r(3'h6, 8'h00);
        w(3'h6, 8'h12);
        w(3'h7, 8'h30);
        r(3'h6, 8'h12);
        r(3'h7, 8'h30);
        w(3'h3, 8'hbf);
        w(3'h2, 8'h70);
        w(3'h3, 8'h00);
        for (k = 0; k < 8; k++) push(k == 2 ? x : 8'($urandom()));
        repeat (2) @(posedge mclk_i);
        #1 chk("rts_n", 16'(rts_n), 16'h0001);
        chk("rx_rdy", 16'(rrdy), 16'(8 >= lvl(4'h3)));
        r(3'h2, iir_f(1'b0, uefc_pkg::IIR_XOFF));
        r(3'h2, iir_f(1'b0, uefc_pkg::IIR_NONE));
        w(3'h7, 8'h00);
        #1 chk("rx_rdy", 16'(rrdy), 16'(8 >= uefc_pkg::RX_FCR_TRIG0));
        for (k = 0; k < 8; k++) begin
            r(3'h0, q.pop_front());
            if (k == 2 || k == 3) begin
                @(posedge mclk_i);
                #1 chk("rts_n", 16'(rts_n), 16'(k == 2));
            end
        end
        w(3'h2, 8'h01);
        for (k = 0; k < 5; k++) begin
            @(posedge mclk_i) {rxe, rxt, mdm} <= src[k];
            w(3'h1, k < 3 ? 8'h0f : 8'h09);
            r(3'h2, iir_f(1'b1, cd[k]));
        end
        w(3'h1, 8'h80);
        @(posedge mclk_i) cts_n <= 1'b1;
        r(3'h2, iir_f(1'b1, uefc_pkg::IIR_CTSRTS));
        w(3'h3, 8'hbf);
        w(3'h2, 8'h90);
        w(3'h3, 8'h00);
        // one more than the depth: the last write must be dropped
        for (k = 0; k < 33; k++) begin
            x = 8'($urandom());
            w(3'h0, x);
            if (k < 32) q.push_back(x);
        end
        chk("tx_valid", 16'(txv), 16'h0000);
        chk("tx_rdy", 16'(trdy), 16'h0000);
        @(posedge mclk_i) begin
            cts_n <= 1'b0;
            run <= 1'b1;
        end
        for (k = 0; k < 400 && u_sh.got_q.size() < 32; k++) @(posedge mclk_i);
        if (k == 400) begin
            n_mismatch++;
            end_of_test();
        end
        repeat (4) @(posedge mclk_i);
        #1 chk("drained", {15'h0000, txv} + 16'(u_sh.got_q.size()), 16'd32);
        for (k = 0; k < 32; k++) chk("tx_data", 16'(u_sh.got_q[k]), 16'(q[k]));
        @(posedge mclk_i) begin
            prx <= x[0];
            ptx <= x[1];
        end
        w(3'h4, 8'h04);
        r(3'h7, {2'b00, x[0], 1'b0, 2'b00, x[1], 1'b1});
        w(3'h7, 8'hff);
        r(3'h7, {2'b00, x[0], 1'b0, 2'b00, x[1], 1'b1});
        end_of_test();
    end
endmodule
